// ### core/urm_pkg.sv
package urm_pkg;

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_DLL = 3'h0;
  localparam logic [2:0] OFF_DLM = 3'h1;
  localparam logic [2:0] OFF_IER = 3'h1;
  localparam logic [2:0] OFF_ISR = 3'h2;
  localparam logic [2:0] OFF_EFR = 3'h2;
  localparam logic [2:0] OFF_LCR = 3'h3;
  localparam logic [2:0] OFF_FLOW_RESUME_CHAR_FIRST = 3'h4;
  localparam logic [2:0] OFF_FLOW_RESUME_CHAR_SECOND = 3'h5;
  localparam logic [2:0] OFF_LSR = 3'h5;
  localparam logic [2:0] OFF_FLOW_PAUSE_CHAR_FIRST = 3'h6;
  localparam logic [2:0] OFF_FLOW_PAUSE_CHAR_SECOND = 3'h7;
  localparam logic [2:0] OFF_SPR = 3'h7;

  // ********************************************************************
  // Field positions and keys
  // ********************************************************************
  localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
  localparam int LCR_DLAB_BIT = 7;
  localparam int EFR_ENH_BIT = 4;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam int XFR_LSR_MODE_BIT = 3;
  localparam int IER_RX_BIT = 0;
  localparam int IER_TX_BIT = 1;
  localparam int IER_LS_BIT = 2;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ********************************************************************
  // Interrupt status codes, bits 5:0
  // ********************************************************************
  localparam logic [5:0] ISR_LSR = 6'h06;
  localparam logic [5:0] ISR_RXRDY = 6'h04;
  localparam logic [5:0] ISR_TXRDY = 6'h02;
  localparam logic [5:0] ISR_NONE = 6'h01;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } urm_bus_pins_t;

  localparam urm_bus_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1,
    wr_n: 1'b1, addr: 3'h0, data: 8'h00};

  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [7:0] data;
  } urm_rx_char_t;

endpackage : urm_pkg

// ### core/urm_regs.sv
// Functional notes
// R1 - DLAB set and line control not 0xBF: offsets 0,1 are divisor bytes
// R2 - Divisor bytes form one 16-bit baud divisor, low byte least significant
// R3 - Identification code reads at offset 1 when divisor access and divisor zero
// R4 - Enhanced and flow character registers reachable only with line control 0xBF
// R5 - Extended bits ignored until enhanced bit 4 is set
// R6 - Interrupt enable mask gates each interrupt source
// R7 - FIFO receive interrupt follows level against trigger, both directions
// R8 - Status shows receive trigger; status and interrupt clear together
// R9 - Data ready sets on character push, clears only when FIFO empty
// R10 - Host polls line status with FIFOs on and enables 0-3 clear
// R11 - Line status bit 1 flags receive overrun
// R12 - Line status bits 2-4 give errors of character at FIFO head
// R13 - Line status bit 5 set while transmit FIFO empty
// R14 - Line status bit 6 set when transmit FIFO and shifter empty
// R15 - Line status bit 7 set while any stored character has an error
// R16 - Receive interrupt: character present, or trigger reached in FIFO mode
// R17 - Transmit interrupt on empty, or falling below trigger in FIFO mode
// R18 - Enabling transmit interrupt while empty raises it at once
// R19 - Change of line status bits 1-4 raises line status interrupt
// R20 - Overrun raises line status interrupt on reception
// R21 - Other errors interrupt at head or on reception by mode bit
// R22 - Receive, transmit and line status enables are zero after reset
`timescale 1ns/1ps

// ********************************************************************
// Character FIFO
// ********************************************************************
module urm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic [CW-1:0] limit_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [CW-1:0] count_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic ready;
    logic valid;
    logic [WIDTH-1:0] head;
  } urm_fifo_st_t;

  urm_fifo_st_t st_q;
  urm_fifo_st_t st_d;
  logic push;
  logic pop;

  always_comb begin
    st_d = st_q;
    push = in_valid_i && st_q.ready;
    pop = out_ready_i && st_q.valid;
    if (push) begin
      st_d.mem[st_q.wp] = in_data_i;
      st_d.wp = (st_q.wp == LAST) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == LAST) ? '0 : st_q.rp + 1'b1;
    end
    st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
    if (flush_i) begin
      st_d.wp = '0;
      st_d.rp = '0;
      st_d.cnt = '0;
    end
    st_d.ready = st_d.cnt < limit_i;
    st_d.valid = st_d.cnt != '0;
    // Head held in a flop so the read port is registered
    st_d.head = st_d.mem[st_d.rp];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign in_ready_o = st_q.ready;
  assign out_valid_o = st_q.valid;
  assign out_data_o = st_q.head;
  assign count_o = st_q.cnt;
endmodule : urm_fifo

// ********************************************************************
// Register file and interrupt logic
// ********************************************************************
module urm_regs #(
  parameter int DEPTH = 32,
  parameter int unsigned RX_TRIG [4] = '{1, 4, 8, 16},
  parameter int unsigned TX_TRIG [4] = '{1, 4, 8, 16},
  // Arbitrary identification and revision values
  parameter logic [7:0] ID_CODE = 8'h5a,
  parameter logic [7:0] REV_CODE = 8'h01
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic irq_o,
  output logic [15:0] baud_divisor_o,
  input wire logic rx_valid_i,
  input wire urm_pkg::urm_rx_char_t rx_char_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic tsr_empty_i
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int RXW = $bits(urm_pkg::urm_rx_char_t);

  typedef struct packed {
    urm_pkg::urm_bus_pins_t s1;
    urm_pkg::urm_bus_pins_t s2;
    urm_pkg::urm_bus_pins_t s3;
    logic oe;
    logic [7:0] dout;
    logic [7:0] line_control;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [7:0] enhanced_function_control;
    logic [7:0] flow_resume_char_first;
    logic [7:0] flow_resume_char_second;
    logic [7:0] flow_pause_char_first;
    logic [7:0] flow_pause_char_second;
    logic [7:0] interrupt_enable_mask;
    logic [7:0] spr;
    logic fifo_en;
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic xfr_mode;
    logic overrun;
    logic lsr_int;
    logic thr_int;
    logic head_flag;
    logic tx_low_prev;
    logic [CW-1:0] err_cnt;
    logic irq;
    logic rx_flush;
    logic tx_flush;
  } urm_st_t;

  localparam urm_st_t ST_RST = '{s1: urm_pkg::PINS_IDLE,
    s2: urm_pkg::PINS_IDLE, s3: urm_pkg::PINS_IDLE, default: '0};

  urm_st_t st_q;
  urm_st_t st_d;
  urm_pkg::urm_bus_pins_t pins;
  urm_pkg::urm_rx_char_t rx_head;
  logic [RXW-1:0] rx_head_raw;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] limit;
  logic rx_head_v;
  logic rx_pop;
  logic tx_push;
  logic rd_ev;
  logic wr_ev;
  logic [2:0] rd_addr;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rdata;
  logic [7:0] line_status;
  logic [5:0] isr_code;
  logic dlab_acc;
  logic enh_acc;
  logic std_acc;
  logic ext_en;
  logic div_zero;
  logic rx_int_c;
  logic tx_low;
  logic head_err_ev;
  logic rx_push;
  logic overrun_ev;

  assign pins = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
    addr: addr_i, data: data_i};
  assign limit = st_q.fifo_en ? CW'(DEPTH) : CW'(1);
  assign rx_head = urm_pkg::urm_rx_char_t'(rx_head_raw);

  // ******************************************************************
  // FIFOs
  // ******************************************************************
  urm_fifo #(.WIDTH(RXW), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(st_q.rx_flush),
    .limit_i(limit),
    .in_valid_i(rx_valid_i),
    .in_data_i(rx_char_i),
    .in_ready_o(rx_ready_o),
    .out_valid_o(rx_head_v),
    .out_data_o(rx_head_raw),
    .out_ready_i(rx_pop),
    .count_o(rx_cnt)
  );

  urm_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(st_q.tx_flush),
    .limit_i(limit),
    .in_valid_i(tx_push),
    .in_data_i(wr_data),
    .in_ready_o(),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_data_o),
    .out_ready_i(tx_ready_i),
    .count_o(tx_cnt)
  );

  // ******************************************************************
  // Decode and status terms
  // ******************************************************************
  always_comb begin
    rd_ev = !st_q.s2.cs_n && !st_q.s2.rd_n &&
      !(!st_q.s3.cs_n && !st_q.s3.rd_n);
    // Write taken on trailing strobe edge, with settled address and data
    wr_ev = !st_q.s3.cs_n && !st_q.s3.wr_n &&
      !(!st_q.s2.cs_n && !st_q.s2.wr_n);
    rd_addr = st_q.s2.addr;
    wr_addr = st_q.s3.addr;
    wr_data = st_q.s3.data;
    enh_acc = st_q.line_control == urm_pkg::LCR_ENH_KEY; // R4
    dlab_acc = st_q.line_control[urm_pkg::LCR_DLAB_BIT] && !enh_acc; // R1
    std_acc = !st_q.line_control[urm_pkg::LCR_DLAB_BIT];
    ext_en = st_q.enhanced_function_control[urm_pkg::EFR_ENH_BIT]; // R5
    div_zero = st_q.div_lo == urm_pkg::DIV_ZERO &&
      st_q.div_hi == urm_pkg::DIV_ZERO;
    rx_pop = rd_ev && std_acc && rd_addr == urm_pkg::OFF_DATA;
    tx_push = wr_ev && std_acc && wr_addr == urm_pkg::OFF_DATA;
    rx_push = rx_valid_i && rx_ready_o;
    overrun_ev = rx_valid_i && !rx_ready_o; // R11
    // R7 R16
    rx_int_c = st_q.fifo_en ?
      rx_cnt >= CW'(RX_TRIG[st_q.rx_trig]) : rx_cnt != '0;
    // R17
    tx_low = st_q.fifo_en ?
      tx_cnt < CW'(TX_TRIG[st_q.tx_trig]) : tx_cnt == '0;
    head_err_ev = rx_head_v && !st_q.head_flag && !rx_pop &&
      (rx_head.brk || rx_head.frm || rx_head.par);
    line_status = {st_q.err_cnt != '0, // R15
      tx_cnt == '0 && tsr_empty_i, // R14
      tx_cnt == '0, // R13
      rx_head_v && rx_head.brk, // R12
      rx_head_v && rx_head.frm,
      rx_head_v && rx_head.par,
      st_q.overrun, // R11
      rx_head_v}; // R9
    // R6 R8
    if (st_q.interrupt_enable_mask[urm_pkg::IER_LS_BIT] && st_q.lsr_int) begin
      isr_code = urm_pkg::ISR_LSR;
    end else if (st_q.interrupt_enable_mask[urm_pkg::IER_RX_BIT] && rx_int_c) begin
      isr_code = urm_pkg::ISR_RXRDY;
    end else if (st_q.interrupt_enable_mask[urm_pkg::IER_TX_BIT] && st_q.thr_int) begin
      isr_code = urm_pkg::ISR_TXRDY;
    end else begin
      isr_code = urm_pkg::ISR_NONE;
    end
  end

  // ******************************************************************
  // Read data
  // ******************************************************************
  always_comb begin
    rdata = urm_pkg::RST_BYTE;
    if (rd_addr == urm_pkg::OFF_LCR) begin
      rdata = st_q.line_control;
    end else if (enh_acc) begin
      case (rd_addr)
        urm_pkg::OFF_EFR: rdata = st_q.enhanced_function_control;
        urm_pkg::OFF_FLOW_RESUME_CHAR_FIRST: rdata = st_q.flow_resume_char_first;
        urm_pkg::OFF_FLOW_RESUME_CHAR_SECOND: rdata = st_q.flow_resume_char_second;
        urm_pkg::OFF_FLOW_PAUSE_CHAR_FIRST: rdata = st_q.flow_pause_char_first;
        urm_pkg::OFF_FLOW_PAUSE_CHAR_SECOND: rdata = st_q.flow_pause_char_second;
        default: rdata = urm_pkg::RST_BYTE;
      endcase
    end else if (dlab_acc) begin
      case (rd_addr)
        urm_pkg::OFF_DLL: rdata = div_zero ? REV_CODE : st_q.div_lo;
        urm_pkg::OFF_DLM: rdata = div_zero ? ID_CODE : st_q.div_hi; // R3
        default: rdata = urm_pkg::RST_BYTE;
      endcase
    end else begin
      case (rd_addr)
        urm_pkg::OFF_DATA: rdata = rx_head.data;
        urm_pkg::OFF_IER: rdata = ext_en ? st_q.interrupt_enable_mask : {4'h0, st_q.interrupt_enable_mask[3:0]};
        urm_pkg::OFF_ISR: rdata = {{2{st_q.fifo_en}}, isr_code};
        urm_pkg::OFF_LSR: rdata = line_status;
        urm_pkg::OFF_SPR: rdata = st_q.spr;
        default: rdata = urm_pkg::RST_BYTE;
      endcase
    end
  end

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.oe = !st_q.s2.cs_n && !st_q.s2.rd_n;
    st_d.rx_flush = 1'b0;
    st_d.tx_flush = 1'b0;
    if (rd_ev) begin
      st_d.dout = rdata;
    end
    if (wr_ev) begin
      if (wr_addr == urm_pkg::OFF_LCR) begin
        st_d.line_control = wr_data;
      end else if (enh_acc) begin
        case (wr_addr)
          urm_pkg::OFF_EFR: st_d.enhanced_function_control = wr_data; // R4
          urm_pkg::OFF_FLOW_RESUME_CHAR_FIRST: st_d.flow_resume_char_first = wr_data;
          urm_pkg::OFF_FLOW_RESUME_CHAR_SECOND: st_d.flow_resume_char_second = wr_data;
          urm_pkg::OFF_FLOW_PAUSE_CHAR_FIRST: st_d.flow_pause_char_first = wr_data;
          urm_pkg::OFF_FLOW_PAUSE_CHAR_SECOND: st_d.flow_pause_char_second = wr_data;
          default: st_d.enhanced_function_control = st_q.enhanced_function_control;
        endcase
      end else if (dlab_acc) begin
        case (wr_addr)
          urm_pkg::OFF_DLL: st_d.div_lo = wr_data; // R1
          urm_pkg::OFF_DLM: st_d.div_hi = wr_data;
          default: st_d.div_lo = st_q.div_lo;
        endcase
      end else begin
        case (wr_addr)
          urm_pkg::OFF_IER: begin
            st_d.interrupt_enable_mask[3:0] = wr_data[3:0];
            if (ext_en) begin
              st_d.interrupt_enable_mask[7:4] = wr_data[7:4]; // R5
            end
          end
          urm_pkg::OFF_ISR: begin
            st_d.fifo_en = wr_data[urm_pkg::FCR_EN_BIT];
            if (wr_data[urm_pkg::FCR_EN_BIT]) begin
              st_d.rx_trig = wr_data[7:6];
              st_d.rx_flush = wr_data[urm_pkg::FCR_RXRST_BIT];
              st_d.tx_flush = wr_data[urm_pkg::FCR_TXRST_BIT];
              if (ext_en) begin
                st_d.tx_trig = wr_data[5:4]; // R5
              end
            end
          end
          urm_pkg::OFF_LSR: begin
            if (ext_en) begin
              st_d.xfr_mode = wr_data[urm_pkg::XFR_LSR_MODE_BIT]; // R5
            end
          end
          urm_pkg::OFF_SPR: st_d.spr = wr_data;
          default: st_d.spr = st_q.spr;
        endcase
      end
    end
    // Stored error count feeds bit 7
    st_d.err_cnt = st_q.err_cnt
      + CW'(rx_push && (rx_char_i.brk || rx_char_i.frm || rx_char_i.par))
      - CW'(rx_pop && rx_head_v &&
            (rx_head.brk || rx_head.frm || rx_head.par)); // R15
    if (st_q.rx_flush) begin
      st_d.err_cnt = '0;
    end
    st_d.head_flag = (rx_pop || st_q.rx_flush) ? 1'b0 :
      (st_q.head_flag || head_err_ev);
    // Line status flags: set wins over read clear
    st_d.overrun = (st_q.overrun &&
      !(rd_ev && std_acc && rd_addr == urm_pkg::OFF_LSR)) || overrun_ev;
    st_d.lsr_int = (st_q.lsr_int &&
      !(rd_ev && std_acc && rd_addr == urm_pkg::OFF_LSR)) ||
      overrun_ev || // R19 R20
      (st_q.xfr_mode ? rx_push &&
        (rx_char_i.brk || rx_char_i.frm || rx_char_i.par) :
        head_err_ev); // R21
    st_d.tx_low_prev = tx_low;
    st_d.thr_int = (st_q.thr_int && !tx_push &&
      !(rd_ev && std_acc && rd_addr == urm_pkg::OFF_ISR &&
        isr_code == urm_pkg::ISR_TXRDY)) ||
      (tx_low && !st_q.tx_low_prev) || // R17
      (wr_ev && std_acc && wr_addr == urm_pkg::OFF_IER && tx_low &&
       wr_data[urm_pkg::IER_TX_BIT] &&
       !st_q.interrupt_enable_mask[urm_pkg::IER_TX_BIT]); // R18
    // R6 R7 R8
    st_d.irq = (st_q.interrupt_enable_mask[urm_pkg::IER_RX_BIT] && rx_int_c) ||
      (st_q.interrupt_enable_mask[urm_pkg::IER_TX_BIT] && st_q.thr_int) ||
      (st_q.interrupt_enable_mask[urm_pkg::IER_LS_BIT] && st_q.lsr_int);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_RST; // R22
    end else begin
      st_q <= st_d;
    end
  end

  assign data_o = st_q.dout;
  assign data_oe_o = st_q.oe;
  assign irq_o = st_q.irq;
  assign baud_divisor_o = {st_q.div_hi, st_q.div_lo}; // R2

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_ier_reset_zero: assert property ( // R22
    $rose(rst_n_i) |-> st_q.interrupt_enable_mask[2:0] == 3'h0)
    else $error("interrupt enables not zero after reset");
  chk_div_low_write: assert property ( // R1
    wr_ev && dlab_acc && wr_addr == urm_pkg::OFF_DLL
    |=> baud_divisor_o[7:0] == $past(wr_data))
    else $error("divisor low byte not written");
  chk_div_high_order: assert property ( // R2
    wr_ev && dlab_acc && wr_addr == urm_pkg::OFF_DLM
    |=> baud_divisor_o[15:8] == $past(wr_data) &&
        $stable(baud_divisor_o[7:0]))
    else $error("divisor high byte misplaced");
  chk_id_read: assert property ( // R3
    rd_ev && dlab_acc && rd_addr == urm_pkg::OFF_DLM && div_zero
    |=> data_o == ID_CODE)
    else $error("identification code not returned");
  chk_efr_gate: assert property ( // R4
    wr_ev && !enh_acc |=> $stable(st_q.enhanced_function_control))
    else $error("enhanced register written outside key");
  chk_ier_upper_lock: assert property ( // R5
    wr_ev && !ext_en |=> $stable(st_q.interrupt_enable_mask[7:4]))
    else $error("upper enable bits written while locked");
  chk_rx_int_irq: assert property ( // R7
    st_q.interrupt_enable_mask[urm_pkg::IER_RX_BIT] && rx_int_c |=> irq_o)
    else $error("receive interrupt missing");
  chk_irq_source: assert property ( // R6
    irq_o |-> $past(isr_code) != urm_pkg::ISR_NONE)
    else $error("interrupt without enabled source");
  chk_ready_bit: assert property ( // R9
    rd_ev && std_acc && rd_addr == urm_pkg::OFF_LSR
    |=> data_o[0] == ($past(rx_cnt) != '0))
    else $error("data ready bit wrong");
  chk_overrun_int: assert property ( // R20
    overrun_ev |=> st_q.overrun && st_q.lsr_int)
    else $error("overrun not flagged at once");
  chk_temt_bit: assert property ( // R14
    rd_ev && std_acc && rd_addr == urm_pkg::OFF_LSR
    |=> data_o[6] == ($past(tx_cnt) == '0 && $past(tsr_empty_i)))
    else $error("transmitter empty bit wrong");
  chk_thr_enable: assert property ( // R18
    wr_ev && std_acc && wr_addr == urm_pkg::OFF_IER && tx_low &&
    wr_data[urm_pkg::IER_TX_BIT] && !st_q.interrupt_enable_mask[urm_pkg::IER_TX_BIT]
    |=> st_q.thr_int ##1 irq_o)
    else $error("transmit interrupt not raised on enable");

  cov_fifo_trigger: cover property (
    st_q.fifo_en && rx_int_c ##1 irq_o);
  cov_overrun: cover property (overrun_ev);
  cov_id_read: cover property (rd_ev && dlab_acc && div_zero);
  cov_head_error: cover property (head_err_ev && !st_q.xfr_mode);
endmodule : urm_regs

// ### sim/urm_host.sv
`timescale 1ns/1ps

// ********************************************************************
// Host processor on the parallel register bus
// ********************************************************************
module urm_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic oe_i,
  output urm_pkg::urm_bus_pins_t pins_o
);

  initial begin
    pins_o = urm_pkg::PINS_IDLE;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    pins_o = '{cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0, addr: a, data: d};
    repeat (4) @(negedge clk_i);
    pins_o.cs_n = 1'b1;
    pins_o.wr_n = 1'b1;
    repeat (2) @(negedge clk_i);
    // Bus released: no stale data left on it
    pins_o.data = ~d;
    repeat (2) @(negedge clk_i);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_i);
    pins_o.addr = a;
    pins_o.cs_n = 1'b0;
    pins_o.rd_n = 1'b0;
    repeat (4) @(negedge clk_i);
    d = oe_i ? rdata_i : 8'hxx;
    pins_o.cs_n = 1'b1;
    pins_o.rd_n = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : rd

  // Line control selects which bank the low offsets reach
  task automatic key(input logic [7:0] line_control);
    wr(urm_pkg::OFF_LCR, line_control);
  endtask : key

endmodule : urm_host

// ### sim/urm_regs_bench.sv
`timescale 1ns/1ps

module urm_regs_bench;
  // Arbitrary identification and revision values
  localparam logic [7:0] ID_V = 8'h3c;
  localparam logic [7:0] REV_V = 8'h02;

  typedef struct packed {
    logic [7:0] line_control;
    logic [2:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } urm_row_t;

  logic clk_i, rst_n_i, irq_o, data_oe_o, rx_valid_i, rx_ready_o;
  logic tx_valid_o, tx_ready_i, tsr_empty_i;
  logic [7:0] data_o, tx_data_o;
  logic [15:0] baud_divisor_o;
  urm_pkg::urm_rx_char_t rx_char_i;
  urm_pkg::urm_bus_pins_t pins;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  urm_row_t rows [14] = '{
    '{8'h80, 3'h1, 1'b0, 8'h00, ID_V},
    '{8'h80, 3'h0, 1'b0, 8'h00, REV_V},
    '{8'h80, 3'h0, 1'b1, 8'h34, 8'h34},
    '{8'h80, 3'h1, 1'b1, 8'h12, 8'h12},
    '{8'h00, 3'h1, 1'b1, 8'hf0, 8'h00},
    '{8'hbf, 3'h2, 1'b1, 8'h10, 8'h10},
    '{8'hbf, 3'h4, 1'b1, 8'h11, 8'h11},
    '{8'hbf, 3'h5, 1'b1, 8'h13, 8'h13},
    '{8'hbf, 3'h6, 1'b1, 8'h19, 8'h19},
    '{8'hbf, 3'h7, 1'b1, 8'h1b, 8'h1b},
    '{8'h00, 3'h4, 1'b1, 8'h55, 8'h00},
    '{8'hbf, 3'h4, 1'b0, 8'h00, 8'h11},
    '{8'h00, 3'h1, 1'b1, 8'hf0, 8'hf0},
    '{8'h00, 3'h1, 1'b1, 8'h00, 8'h00}
  };

  urm_regs #(.ID_CODE(ID_V), .REV_CODE(REV_V)) urm_regs_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(pins.cs_n),
    .rd_n_i(pins.rd_n), .wr_n_i(pins.wr_n), .addr_i(pins.addr),
    .data_i(pins.data), .data_o(data_o), .data_oe_o(data_oe_o),
    .irq_o(irq_o), .baud_divisor_o(baud_divisor_o),
    .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
    .tsr_empty_i(tsr_empty_i)
  );

  urm_host urm_host_i (.clk_i(clk_i), .rdata_i(data_o),
    .oe_i(data_oe_o), .pins_o(pins));

  // ********************************************************************
  // Checking and closing
  // ********************************************************************
  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic rchk(input string n, input logic [2:0] a,
                      input logic [7:0] e);
    logic [7:0] d;
    urm_host_i.rd(a, d);
    chk_byte(n, e, d);
  endtask : rchk

  task automatic chk_irq(input logic e);
    repeat (6) @(negedge clk_i);
    chk_bit("irq", e, irq_o);
  endtask : chk_irq

  // Offers one character; held until taken or refused four cycles
  task automatic push(input logic [2:0] err, input logic [7:0] d);
    int n;
    @(negedge clk_i);
    rx_valid_i = 1'b1;
    rx_char_i = urm_pkg::urm_rx_char_t'({err, d});
    n = 0;
    while (rx_ready_o !== 1'b1 && n < 3) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    rx_valid_i = 1'b0;
    rx_char_i = ~rx_char_i;
  endtask : push

  task close_out;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      close_out();
    end
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    rst_n_i = 1'b0;
    rx_valid_i = 1'b0;
    rx_char_i = '0;
    tx_ready_i = 1'b0;
    tsr_empty_i = 1'b1;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_bit("irq", 1'b0, irq_o);
    rchk("enable mask", urm_pkg::OFF_IER, 8'h00);
    rchk("line status", urm_pkg::OFF_LSR, 8'h60);
    foreach (rows[i]) begin
      urm_host_i.key(rows[i].line_control);
      if (rows[i].wr) begin
        urm_host_i.wr(rows[i].addr, rows[i].wdata);
      end
      rchk("register", rows[i].addr, rows[i].exp);
    end
    chk_byte("divisor high", 8'h12, baud_divisor_o[15:8]);
    chk_byte("divisor low", 8'h34, baud_divisor_o[7:0]);
    // Receive trigger of four in FIFO mode
    urm_host_i.wr(urm_pkg::OFF_ISR, 8'h41);
    urm_host_i.wr(urm_pkg::OFF_IER, 8'h01);
    for (int i = 0; i < 3; i++) push(3'b000, 8'h20 + 8'(i));
    chk_irq(1'b0);
    push(3'b000, 8'h23);
    chk_irq(1'b1);
    rchk("status", urm_pkg::OFF_ISR, 8'hc4);
    rchk("rx data", urm_pkg::OFF_DATA, 8'h20);
    chk_irq(1'b0);
    rchk("status", urm_pkg::OFF_ISR, 8'hc1);
    rchk("line status", urm_pkg::OFF_LSR, 8'h61);
    for (int i = 1; i < 4; i++) begin
      rchk("rx data", urm_pkg::OFF_DATA, 8'h20 + 8'(i));
    end
    rchk("line status", urm_pkg::OFF_LSR, 8'h60);
    // Transmit ready, shifter stalled
    urm_host_i.wr(urm_pkg::OFF_IER, 8'h02);
    chk_irq(1'b1);
    rchk("status", urm_pkg::OFF_ISR, 8'hc2);
    chk_irq(1'b0);
    // Enable again with the flag cleared and the holding side empty
    urm_host_i.wr(urm_pkg::OFF_IER, 8'h00);
    urm_host_i.wr(urm_pkg::OFF_IER, 8'h02);
    chk_irq(1'b1);
    rchk("status", urm_pkg::OFF_ISR, 8'hc2);
    urm_host_i.wr(urm_pkg::OFF_DATA, 8'ha5);
    chk_irq(1'b0);
    chk_bit("tx valid", 1'b1, tx_valid_o);
    chk_byte("tx data", 8'ha5, tx_data_o);
    rchk("line status", urm_pkg::OFF_LSR, 8'h00);
    tsr_empty_i = 1'b0;
    tx_ready_i = 1'b1;
    @(negedge clk_i);
    tx_ready_i = 1'b0;
    chk_irq(1'b1);
    rchk("line status", urm_pkg::OFF_LSR, 8'h20);
    tsr_empty_i = 1'b1;
    // Overrun and character errors, FIFOs off
    urm_host_i.wr(urm_pkg::OFF_ISR, 8'h00);
    urm_host_i.wr(urm_pkg::OFF_IER, 8'h04);
    push(3'b000, 8'h11);
    chk_irq(1'b0);
    chk_bit("rx ready", 1'b0, rx_ready_o);
    push(3'b000, 8'h22);
    chk_irq(1'b1);
    rchk("line status", urm_pkg::OFF_LSR, 8'h63);
    chk_irq(1'b0);
    rchk("rx data", urm_pkg::OFF_DATA, 8'h11);
    push(3'b110, 8'h33);
    chk_irq(1'b1);
    rchk("line status", urm_pkg::OFF_LSR, 8'hf9);
    // Errors flagged on reception, FIFOs on, error behind a clean head
    urm_host_i.wr(urm_pkg::OFF_ISR, 8'h07);
    urm_host_i.wr(urm_pkg::OFF_LSR, 8'h08);
    push(3'b000, 8'h44);
    push(3'b001, 8'h55);
    chk_irq(1'b1);
    rchk("line status", urm_pkg::OFF_LSR, 8'he1);
    // Polled operation: enables cleared, status still readable
    urm_host_i.wr(urm_pkg::OFF_IER, 8'h00);
    chk_irq(1'b0);
    rchk("line status", urm_pkg::OFF_LSR, 8'he1);
    close_out();
  end

endmodule : urm_regs_bench
